// ==== xcvr_defines.vh ====
// Constants for the bidirectional latch/register transceiver
`ifndef XCVR_DEFINES_VH
`define XCVR_DEFINES_VH
`define XCVR_WIDTH 18
`define XCVR_FIFO_DEPTH 16
`define XCVR_FIFO_AW 4
`define XCVR_REG_CTRL 12'h000
`define XCVR_REG_FWD_DATA 12'h004
`define XCVR_REG_REV_DATA 12'h008
`define XCVR_REG_STATUS 12'h00C
`define XCVR_REG_FIFO 12'h010
`define XCVR_CTRL_RESET 32'h00000024
`define XCVR_FWD_CE_BIT 0
`define XCVR_FWD_LE_BIT 1
`define XCVR_FWD_OE_BIT 2
`define XCVR_REV_CE_BIT 3
`define XCVR_REV_LE_BIT 4
`define XCVR_REV_OE_BIT 5
`define XCVR_CTRL_MASK 32'h0000003F
`endif

// ==== xcvr_fifo.v ====
// Capture FIFO is kept in bidir_xcvr.v beside the logic that fills it

// ==== bidir_xcvr.v ====
// Bidirectional 18-bit latch/register transceiver with APB control
// Operation
// - Data passes noninverted in every mode.
// - Each direction carries 18 bits under one CE and one OE.
// - OE_n low drives destination port; high releases it.
// - Latch enable high makes destination follow source, ignoring clock.
// - CE low, LE low: rising clock captures source data.
// - Falling latch enable holds the last source value.
// - CE low, LE low, steady clock: stored value held.
// - Clock updates storage only while CE low; else hold.
// - Clock high at LE fall holds; later clock rise may update.
// - Reverse path mirrors forward path with its own controls.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "xcvr_defines.vh"
module bidir_xcvr (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Card-side port
  input wire [`XCVR_WIDTH-1:0] cardIn,
  output wire [`XCVR_WIDTH-1:0] cardOut,
  output wire cardOe,
  // Backplane port
  input wire [`XCVR_WIDTH-1:0] busIn,
  output wire [`XCVR_WIDTH-1:0] busOut,
  output wire busOe,
  // Direction clocks, sampled as inputs
  input wire fwdClock,
  input wire revClock,
  // Capture FIFO drain
  output wire capValid,
  input wire capReady,
  output wire [`XCVR_WIDTH-1:0] capData
);
  wire apbWr;
  wire apbRd;
  reg [31:0] ctrl_ff;
  reg fwdClkPrev_ff;
  reg revClkPrev_ff;
  reg [`XCVR_WIDTH-1:0] fwdStore_ff;
  reg [`XCVR_WIDTH-1:0] revStore_ff;
  reg [`XCVR_WIDTH-1:0] fwdOut_ff;
  reg [`XCVR_WIDTH-1:0] revOut_ff;
  reg bothOn_ff;
  wire fwdCeN;
  wire fwdLe;
  wire fwdOeN;
  wire revCeN;
  wire revLe;
  wire revOeN;
  wire fwdRise;
  wire revRise;
  wire fwdLoad;
  wire revLoad;
  wire fifoInReady;
  wire [`XCVR_FIFO_AW:0] fifoLevel;
  wire regHit;

  // Storage load: transparent latch or enabled clock rise
  function loadCond;
    input le;
    input ceN;
    input rise;
    begin
      loadCond = le | (~ceN & rise);
    end
  endfunction

  assign fwdCeN = ctrl_ff[`XCVR_FWD_CE_BIT];
  assign fwdLe = ctrl_ff[`XCVR_FWD_LE_BIT];
  assign fwdOeN = ctrl_ff[`XCVR_FWD_OE_BIT];
  assign revCeN = ctrl_ff[`XCVR_REV_CE_BIT];
  assign revLe = ctrl_ff[`XCVR_REV_LE_BIT];
  assign revOeN = ctrl_ff[`XCVR_REV_OE_BIT];

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !pwrite;
  // Single-cycle access phase, no wait states
  assign pready = 1'b1;
  assign regHit = (paddr == `XCVR_REG_CTRL) || (paddr == `XCVR_REG_FWD_DATA) ||
    (paddr == `XCVR_REG_REV_DATA) || (paddr == `XCVR_REG_STATUS) ||
    (paddr == `XCVR_REG_FIFO);
  assign pslverr = psel && penable && !regHit;

  // Clock edge seen as sampled rising level
  assign fwdRise = fwdClock & ~fwdClkPrev_ff;
  assign revRise = revClock & ~revClkPrev_ff;
  // Clock gated by CE only; LE high overrides
  assign fwdLoad = loadCond(fwdLe, fwdCeN, fwdRise);
  assign revLoad = loadCond(revLe, revCeN, revRise);

  always @(posedge mclk) begin
    if (!nrst) begin
      ctrl_ff <= `XCVR_CTRL_RESET;
      fwdClkPrev_ff <= 1'b0;
      revClkPrev_ff <= 1'b0;
      bothOn_ff <= 1'b0;
    end else begin
      if (apbWr && paddr == `XCVR_REG_CTRL) begin
        ctrl_ff <= pwdata & `XCVR_CTRL_MASK;
      end
      fwdClkPrev_ff <= fwdClock;
      revClkPrev_ff <= revClock;
      // Sticky flag of a forbidden dual drive; set wins over clear
      if (!fwdOeN && !revOeN) begin
        bothOn_ff <= 1'b1;
      end else if (apbWr && paddr == `XCVR_REG_STATUS && pwdata[0]) begin
        bothOn_ff <= 1'b0;
      end
    end
  end

  // No reset on data storage: undefined until loaded
  always @(posedge mclk) begin
    if (fwdLoad) begin
      fwdStore_ff <= cardIn;
    end
    if (revLoad) begin
      revStore_ff <= busIn;
    end
  end

  // Registered outputs; transparent path shows input one cycle late
  always @(posedge mclk) begin
    if (fwdLoad) begin
      fwdOut_ff <= cardIn;
    end else begin
      fwdOut_ff <= fwdStore_ff;
    end
    if (revLoad) begin
      revOut_ff <= busIn;
    end else begin
      revOut_ff <= revStore_ff;
    end
  end

  assign busOut = fwdOut_ff;
  assign busOe = !fwdOeN;
  assign cardOut = revOut_ff;
  assign cardOe = !revOeN;

  // Clocked forward captures logged; a capture made while the FIFO is full is dropped from the log
  xcvr_fifo #(
    .WIDTH(`XCVR_WIDTH),
    .DEPTH(`XCVR_FIFO_DEPTH),
    .AW(`XCVR_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .inValid(fwdLoad && !fwdLe),
    .inReady(fifoInReady),
    .inData(cardIn),
    .outValid(capValid),
    .outReady(capReady),
    .outData(capData),
    .level(fifoLevel)
  );

  always @* begin
    prdata = 32'h00000000;
    if (apbRd) begin
      case (paddr)
        `XCVR_REG_CTRL: prdata = ctrl_ff;
        `XCVR_REG_FWD_DATA: prdata = {14'h0000, fwdOut_ff};
        `XCVR_REG_REV_DATA: prdata = {14'h0000, revOut_ff};
        `XCVR_REG_STATUS: prdata = {26'h0000000, fifoLevel, bothOn_ff};
        `XCVR_REG_FIFO: prdata = {13'h0000, fifoInReady, capData};
        default: prdata = 32'h00000000;
      endcase
    end
  end
endmodule // bidir_xcvr

// Synchronous FIFO with valid/ready on both sides
module xcvr_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0] level
);
  // Count is one bit wider than the pointers so full and empty differ
  localparam [AW:0] FULL_COUNT = DEPTH;
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;
  assign inReady = (count_ff != FULL_COUNT);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData = mem_ff[rdPtr_ff];
  assign level = count_ff;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always @(posedge mclk) begin
    if (push) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end
  always @(posedge mclk) begin
    if (!nrst) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // xcvr_fifo

// ==== xcvr_chk.sv ====
// Port assertions for the transceiver
`timescale 1ns/100ps
module xcvr_chk (
  // Clock, reset
  input wire mclk,
  input wire nrst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Data ports
  input wire [17:0] cardIn,
  input wire [17:0] cardOut,
  input wire cardOe,
  input wire [17:0] busIn,
  input wire [17:0] busOut,
  input wire busOe,
  input wire fwdClock
);
  reg [5:0] ctrl_ff;
  reg seen_ff;
  wire ctrlWr = psel && penable && pwrite && paddr == 12'h000;
  // Storage is X until loaded, so hold checks wait for a load
  always @(posedge mclk) begin
    if (!nrst) ctrl_ff <= 6'h24;
    else if (ctrlWr) ctrl_ff <= pwdata[5:0];
    if (!nrst) seen_ff <= 1'b0;
    else if (ctrl_ff[1]) seen_ff <= 1'b1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence rise;
    ctrl_ff[1:0] == 2'h0 && $rose(fwdClock);
  endsequence
  sequence quiet;
    seen_ff && ctrl_ff[1:0] == 2'h0 && $past(ctrl_ff[1:0]) == 2'h0
    && fwdClock == $past(fwdClock) && fwdClock == $past(fwdClock, 3);
  endsequence
  a_fwd_oe: assert property (ctrlWr |=> busOe == !$past(pwdata[2]))
    else $error("fwd oe");
  a_rev_oe: assert property (ctrlWr |=> cardOe == !$past(pwdata[5]))
    else $error("rev oe");
  a_fwd_follow: assert property (ctrl_ff[1] |=> busOut == $past(cardIn))
    else $error("fwd follow");
  a_rev_follow: assert property (ctrl_ff[4] |=> cardOut == $past(busIn))
    else $error("rev follow");
  a_fwd_capture: assert property (rise |-> ##[1:2] busOut == cardIn)
    else $error("capture");
  a_fwd_inhibit: assert property (
    seen_ff && ctrl_ff[1:0] == 2'h1 && $past(ctrl_ff[1:0]) == 2'h1 |=> $stable(busOut))
    else $error("inhibit");
  a_fwd_latch: assert property ($fell(ctrl_ff[1]) && ctrl_ff[0] |=> $stable(busOut))
    else $error("latch");
  a_fwd_steady: assert property (quiet |=> $stable(busOut))
    else $error("steady");
endmodule // xcvr_chk

// ==== far_end.sv ====
// Card logic and backplane resolving the shared wires
`timescale 1ns/100ps
module far_end (
  // From the transceiver
  input wire [17:0] busOut,
  input wire busOe,
  input wire [17:0] cardOut,
  input wire cardOe,
  // Other parties' levels
  input wire [17:0] busDrv,
  input wire [17:0] cardDrv,
  // Wire levels
  output wire [17:0] busIn,
  output wire [17:0] cardIn
);
  assign busIn = busOe ? busOut : busDrv;
  assign cardIn = cardOe ? cardOut : cardDrv;
endmodule // far_end

// ==== tb_top.sv ====
// Testbench for the transceiver
`timescale 1ns/100ps
module tb_top;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, capReady = 0;
  logic fwdClock = 0, revClock = 0, pready, pslverr, cardOe, busOe, capValid, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [17:0] cardIn, cardOut, busIn, busOut, capData, cardDrv = 0, busDrv = 0;
  logic [23:0] rows [4] = '{{6'h32, 18'h2AAAA}, {6'h16, 18'h15555},
    {6'h36, 18'h3FFFF}, {6'h32, 18'h00000}};
  int fails = 0, checksDone = 0, cyc = 0, k;
  bidir_xcvr DUT (.*);
  far_end partner (.*);
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      fails++;
      finish_test();
    end
  end
  task chk(input [18:0] got, input [18:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse(input rev);
    @(posedge mclk);
    if (rev) revClock <= 1;
    else fwdClock <= 1;
    repeat (2) @(posedge mclk);
    fwdClock <= 0;
    revClock <= 0;
    repeat (3) @(posedge mclk);
  endtask
  task finish_test;
    if (fails == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1;
    @(posedge mclk);
    chk({busOe, cardOe}, 0);
    // Never both enables low: both ports would drive
    foreach (rows[i]) begin
      apb(12'h000, 1, rows[i][23:18]);
      cardDrv <= rows[i][17:0];
      busDrv <= rows[i][17:0];
      repeat (4) @(posedge mclk);
      chk({busOe, cardOe}, {!rows[i][20], !rows[i][23]});
      chk(busOut, rows[i][17:0]);
      chk(cardOut, rows[i][17:0]);
    end
    apb(12'h000, 1, 32'h20);
    for (k = 0; k < 17; k++) begin
      cardDrv <= 18'h100 + 18'(k);
      pulse(0);
    end
    chk(busOut, 18'h110);
    cardDrv <= 18'h3C3C3;
    repeat (4) @(posedge mclk);
    chk(busOut, 18'h110);
    apb(12'h000, 1, 32'h21);
    pulse(0);
    chk(busOut, 18'h110);
    apb(12'h000, 1, 32'h23);
    apb(12'h000, 1, 32'h21);
    cardDrv <= 18'h0F0F0;
    pulse(0);
    chk(busOut, 18'h3C3C3);
    apb(12'h004, 0, 0);
    chk(rd[17:0], 18'h3C3C3);
    apb(12'h100, 0, 0);
    chk(err, 1);
    capReady <= 1;
    for (k = 0; k < 16; k++) begin
      @(negedge mclk);
      chk({capValid, capData}, {1'b1, 18'h100 + 18'(k)});
    end
    @(negedge mclk);
    chk(capValid, 0);
    apb(12'h000, 1, 32'h04);
    busDrv <= 18'h2D2D2;
    pulse(1);
    chk(cardOut, 18'h2D2D2);
    finish_test();
  end
endmodule // tb_top
bind bidir_xcvr xcvr_chk watch (.*);
